// ==== dir_pkg.sv ====
/*
 * dir_pkg: constants and carrier types for the digital input
 * reference control block.
 * assumes: frequencies are in 0.1 % steps of maximum output frequency.
 */
package dir_pkg;

    // frequency word: 0.1 % of maximum output frequency per step
    localparam int FW = 12;
    // ramp step spacing word, in clk_sys cycles
    localparam int TW = 16;
    // number of multi-function digital input terminals
    localparam int NIN = 5;

    // function codes for the terminal function selects
    localparam int NFN = 8;
    localparam logic [7:0] FN_CODE [0:NFN-1] = '{
        8'h0C, 8'h6A, 8'h70, 8'h0A, 8'h10, 8'h11, 8'h1C, 8'h1D
    };
    // index into FN_CODE
    localparam int FN_SEC_EN = 0;
    localparam int FN_DRV_EN = 1;
    localparam int FN_BYP_EN = 2;
    localparam int FN_RHOLD  = 3;
    localparam int FN_UP     = 4;
    localparam int FN_DOWN   = 5;
    localparam int FN_TINC   = 6;
    localparam int FN_TDEC   = 7;

    // limit and trim settings after reset of the surrounding config
    localparam logic [FW-1:0] UPPER_LIMIT_RST = 12'h3E8;
    localparam logic [FW-1:0] LOWER_LIMIT_RST = 12'h000;
    localparam logic [FW-1:0] LIMIT_MAX       = 12'h44C;
    localparam logic [6:0]    TRIM_LEVEL_RST  = 7'h0A;
    localparam logic [6:0]    TRIM_LEVEL_MAX  = 7'h64;
    // one percent in frequency steps
    localparam logic [FW-1:0] PCT_STEPS       = 12'h00A;
    localparam logic          HOLD_SEL_RST    = 1'b0;
    localparam logic          STOP_COAST      = 1'b1;

    // cycles after reset release before terminals are trusted;
    // covers the two synchroniser stages
    localparam logic [1:0] PWRUP_SETTLE_CYC = 2'h3;

    typedef struct packed {
        logic [FW-1:0] upper_limit;
        logic [FW-1:0] lower_limit;
        logic [FW-1:0] master_lower_limit;
        logic [6:0]    trim_level;
        logic          hold_select;
        logic          stop_coast;
        logic          ref_src_analog;
    } dir_cfg_t;

    typedef struct packed {
        logic drive_not_enabled_alarm;
        logic input_config_error;
        logic speed_agree;
        logic secondary_analog_enable;
        logic multistep_disable;
        logic motor_run;
    } dir_stat_t;

endpackage

// ==== dir_ramp.sv ====
/*
 * dir_ramp: acceleration/deceleration ramp toward a target frequency.
 * assumes: step spacing inputs are static during a ramp; zero means
 * one step per cycle.
 */
`timescale 1ns/1ps
module dir_ramp #(
    parameter int FW = dir_pkg::FW,
    parameter int TW = dir_pkg::TW
) (
    input  wire logic          clk_sys,
    input  wire logic          reset,
    input  wire logic [FW-1:0] target,
    input  wire logic          hold,
    input  wire logic          coast,
    input  wire logic [TW-1:0] accel_cyc,
    input  wire logic [TW-1:0] decel_cyc,
    output logic      [FW-1:0] freq_ff,
    output logic               accel,
    output logic               decel
);
    logic [TW-1:0] tick_ff;
    logic [TW-1:0] nxt_tick;
    logic [FW-1:0] nxt_freq;
    wire  logic          below  = freq_ff < target;
    wire  logic          above  = freq_ff > target;
    wire  logic [TW-1:0] period = below ? accel_cyc : decel_cyc;
    wire  logic          step   = tick_ff >= period;

    assign accel = below & ~hold & ~coast;
    assign decel = above & ~hold & ~coast;

    always_comb begin
        nxt_tick = tick_ff;
        nxt_freq = freq_ff;
        if (coast) begin
            nxt_tick = '0;
            nxt_freq = '0;
        end else if (hold || !(below || above)) begin
            nxt_tick = '0;
        end else if (step) begin
            nxt_tick = '0;
            nxt_freq = below ? freq_ff + 1'b1 : freq_ff - 1'b1;
        end else begin
            nxt_tick = tick_ff + 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            tick_ff <= '0;
            freq_ff <= '0;
        end else begin
            tick_ff <= nxt_tick;
            freq_ff <= nxt_freq;
        end
    end

    ramp_hold_a: assert property (
        @(posedge clk_sys) disable iff (reset)
        hold && !coast |=> freq_ff == $past(freq_ff))
        else $error("frequency moved during ramp hold");

    ramp_rate_a: assert property (
        @(posedge clk_sys) disable iff (reset)
        !hold && !coast && tick_ff < period && freq_ff != target
        |=> freq_ff == $past(freq_ff))
        else $error("ramp stepped before its period ran out");
endmodule

// ==== dir_ctrl.sv ====
/*
 * dir_ctrl: turns multi-function digital input terminals into
 * reference, run gating and alarm behaviour for the output stage.
 * assumes: terminal pins and the run pin are asynchronous; function
 * selects, limits, analog words and the non-volatile word are on
 * clk_sys. The non-volatile store shows a written word on nv_value
 * from the cycle after nv_write.
 */
`timescale 1ns/1ps
module dir_ctrl #(
    parameter int NIN = dir_pkg::NIN,
    parameter int FW  = dir_pkg::FW,
    parameter int TW  = dir_pkg::TW
) (
    input  wire logic                clk_sys,
    input  wire logic                reset,
    input  wire logic [NIN-1:0]      din_pins,
    input  wire logic                run_pin,
    input  wire logic [NIN-1:0][7:0] input_function_select,
    input  wire dir_pkg::dir_cfg_t   cfg,
    input  wire logic [FW-1:0]       primary_analog_input,
    input  wire logic [FW-1:0]       base_reference,
    input  wire logic [TW-1:0]       accel_cyc,
    input  wire logic [TW-1:0]       decel_cyc,
    input  wire logic [FW-1:0]       nv_value,
    output logic      [FW-1:0]       output_freq,
    output logic      [FW-1:0]       nv_wdata_ff,
    output logic                     nv_write_ff,
    output dir_pkg::dir_stat_t       stat_ff
);
    // synchronisers: stage one is read only by stage two
    logic [NIN:0] pin_meta_ff;
    logic [NIN:0] pin_sync_ff;
    wire  logic [NIN-1:0] din_s = pin_sync_ff[NIN-1:0];
    wire  logic           run_s = pin_sync_ff[NIN];

    // function decode, one row per function code
    logic [dir_pkg::NFN-1:0] fn_has;
    logic [dir_pkg::NFN-1:0] fn_act;
    genvar k;
    generate
        for (k = 0; k < dir_pkg::NFN; k++) begin : g_fn
            logic [NIN-1:0] hit;
            genvar i;
            for (i = 0; i < NIN; i++) begin : g_in
                assign hit[i] =
                    input_function_select[i] == dir_pkg::FN_CODE[k];
            end
            assign fn_has[k] = |hit;
            assign fn_act[k] = |(hit & din_s);
        end
    endgenerate

    wire logic has_up   = fn_has[dir_pkg::FN_UP];
    wire logic has_dn   = fn_has[dir_pkg::FN_DOWN];
    wire logic has_rh   = fn_has[dir_pkg::FN_RHOLD];
    wire logic has_ti   = fn_has[dir_pkg::FN_TINC];
    wire logic has_td   = fn_has[dir_pkg::FN_TDEC];
    wire logic act_up   = fn_act[dir_pkg::FN_UP];
    wire logic act_dn   = fn_act[dir_pkg::FN_DOWN];
    wire logic act_rh   = fn_act[dir_pkg::FN_RHOLD];
    wire logic has_byp  = fn_has[dir_pkg::FN_BYP_EN];
    wire logic act_byp  = fn_act[dir_pkg::FN_BYP_EN];
    wire logic has_den  = fn_has[dir_pkg::FN_DRV_EN];
    wire logic act_den  = fn_act[dir_pkg::FN_DRV_EN];

    // configuration check
    wire logic ud_pair_err = has_up ^ has_dn;
    wire logic ud_rh_err   = (has_up | has_dn) & has_rh;
    wire logic trim_err    = has_ti ^ has_td;
    wire logic cfg_err     = ud_pair_err | ud_rh_err | trim_err;

    // run gating
    logic run_prev_ff;
    logic run_lat_ff;
    logic nxt_run_lat;
    logic go_prev_ff;
    wire  logic drv_en_ok = ~has_den | act_den;
    wire  logic byp_ok    = ~has_byp | act_byp;
    wire  logic run_rise  = run_s & ~run_prev_ff;
    // enable must be on at the run edge; later enable needs a new edge
    always_comb begin
        nxt_run_lat = run_lat_ff;
        if (!run_s || !drv_en_ok) begin
            nxt_run_lat = 1'b0;
        end else if (run_rise) begin
            nxt_run_lat = 1'b1;
        end
    end
    // bypass enable needs no new run edge
    wire logic run_go   = run_lat_ff & byp_ok & ~cfg_err;
    wire logic go_rise  = run_go & ~go_prev_ff;
    wire logic coast    = ~run_go & cfg.stop_coast;

    // ramp instance and its status
    logic [FW-1:0] target;
    logic          ramp_hold;
    logic          accel;
    logic          decel;
    dir_ramp #(
        .FW (FW),
        .TW (TW)
    ) u_ramp (
        .clk_sys   (clk_sys),
        .reset     (reset),
        .target    (target),
        .hold      (ramp_hold),
        .coast     (coast),
        .accel_cyc (accel_cyc),
        .decel_cyc (decel_cyc),
        .freq_ff   (output_freq),
        .accel     (accel),
        .decel     (decel)
    );

    // limits for raise/lower mode
    wire logic [FW-1:0] lo_par = (cfg.lower_limit > cfg.master_lower_limit)
        ? cfg.lower_limit : cfg.master_lower_limit;
    wire logic [FW-1:0] lo_eff = (primary_analog_input > lo_par)
        ? primary_analog_input : lo_par;
    function automatic logic [FW-1:0] clampf(input logic [FW-1:0] v,
                                             input logic [FW-1:0] lo,
                                             input logic [FW-1:0] hi);
        logic [FW-1:0] r;
        r = v;
        if (r < lo) begin
            r = lo;
        end
        if (r > hi) begin
            r = hi;
        end
        return r;
    endfunction

    // raise/lower reference
    wire logic ud_mode = has_up & has_dn & ~cfg_err;
    wire logic up_only = ud_mode & act_up & ~act_dn;
    wire logic dn_only = ud_mode & act_dn & ~act_up;
    logic          ud_move_prev_ff;
    logic [FW-1:0] ud_hold_ff;
    logic [FW-1:0] nxt_ud_hold;
    wire  logic [FW-1:0] ud_seed = cfg.hold_select ? nv_value : '0;
    always_comb begin
        nxt_ud_hold = ud_hold_ff;
        if (go_rise) begin
            nxt_ud_hold = ud_seed;
        end else if (up_only || dn_only) begin
            nxt_ud_hold = output_freq;
        end
    end
    wire logic [FW-1:0] ud_hold_ref = clampf(ud_hold_ff, lo_eff,
                                             cfg.upper_limit);
    wire logic [FW-1:0] ud_target = up_only ? cfg.upper_limit
                                  : dn_only ? lo_eff : ud_hold_ref;
    wire logic ud_release = ud_move_prev_ff & ~(up_only | dn_only);

    // trim of an analog reference
    wire logic [FW-1:0] trim_amt = FW'(cfg.trim_level) *
                                   dir_pkg::PCT_STEPS;
    wire logic trim_en = has_ti & has_td & ~cfg_err & cfg.ref_src_analog
                       & (base_reference != '0);
    wire logic ti_only = trim_en & fn_act[dir_pkg::FN_TINC]
                       & ~fn_act[dir_pkg::FN_TDEC];
    wire logic td_only = trim_en & fn_act[dir_pkg::FN_TDEC]
                       & ~fn_act[dir_pkg::FN_TINC];
    wire logic [FW:0]   trim_sum = {1'b0, base_reference} + {1'b0, trim_amt};
    wire logic [FW-1:0] trim_up  = trim_sum[FW] ? '1 : trim_sum[FW-1:0];
    wire logic [FW-1:0] trim_dn  = (base_reference < trim_amt)
        ? '0 : base_reference - trim_amt;
    wire logic [FW-1:0] trim_ref = ti_only ? trim_up
                                 : td_only ? trim_dn
                                 : base_reference;

    // ramp hold mode and its restore after power loss
    wire logic rh_mode  = has_rh & ~cfg_err;
    wire logic rh_on    = rh_mode & act_rh;
    logic      rh_prev_ff;
    logic      restore_ff;
    logic      nxt_restore;
    wire logic rh_rise  = rh_on & ~rh_prev_ff & run_go;

    // power-up settle, then sample terminals for the clear request
    logic [1:0] pwr_cnt_ff;
    wire  logic pwr_done = pwr_cnt_ff == dir_pkg::PWRUP_SETTLE_CYC;
    wire  logic pwr_edge = pwr_cnt_ff == dir_pkg::PWRUP_SETTLE_CYC - 2'h1;
    wire  logic pwr_clear = pwr_edge & cfg.hold_select
                          & (|(din_s & {NIN{1'b1}})) & (act_up | act_dn);

    always_comb begin
        nxt_restore = restore_ff;
        if (pwr_edge) begin
            nxt_restore = cfg.hold_select & rh_mode;
        end else if (run_go && rh_prev_ff && !rh_on) begin
            nxt_restore = 1'b0;
        end
    end
    wire logic [FW-1:0] norm_ref = restore_ff ? nv_value : trim_ref;

    // frequency target; stop wins over every hold
    assign ramp_hold = rh_on & run_go;
    assign target    = !run_go ? '0
                     : ud_mode ? ud_target
                     : norm_ref;

    // non-volatile write requests
    logic          nxt_nv_write;
    logic [FW-1:0] nxt_nv_wdata;
    always_comb begin
        nxt_nv_write = 1'b0;
        nxt_nv_wdata = nv_wdata_ff;
        if (pwr_clear) begin
            nxt_nv_write = 1'b1;
            nxt_nv_wdata = '0;
        end else if (cfg.hold_select && pwr_done) begin
            if (rh_rise) begin
                nxt_nv_write = 1'b1;
                nxt_nv_wdata = output_freq;
            end else if (ud_release && run_go) begin
                nxt_nv_write = 1'b1;
                nxt_nv_wdata = ud_hold_ref;
            end
        end
    end

    // status
    dir_pkg::dir_stat_t nxt_stat;
    always_comb begin
        nxt_stat = '0;
        nxt_stat.drive_not_enabled_alarm =
            run_s & has_byp & ~act_byp;
        nxt_stat.input_config_error = cfg_err;
        nxt_stat.speed_agree = run_s & ~accel & ~decel;
        // unassigned code C leaves the input enabled
        nxt_stat.secondary_analog_enable = ~fn_has[dir_pkg::FN_SEC_EN]
            | fn_act[dir_pkg::FN_SEC_EN];
        nxt_stat.multistep_disable = ud_mode;
        nxt_stat.motor_run = run_go | (output_freq != '0);
    end

    always_ff @(posedge clk_sys) begin
        pin_meta_ff <= {run_pin, din_pins};
        pin_sync_ff <= pin_meta_ff;
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            run_prev_ff     <= 1'b0;
            run_lat_ff      <= 1'b0;
            go_prev_ff      <= 1'b0;
            ud_move_prev_ff <= 1'b0;
            ud_hold_ff      <= '0;
            rh_prev_ff      <= 1'b0;
            restore_ff      <= 1'b0;
            pwr_cnt_ff      <= '0;
        end else begin
            run_prev_ff     <= run_s;
            run_lat_ff      <= nxt_run_lat;
            go_prev_ff      <= run_go;
            ud_move_prev_ff <= up_only | dn_only;
            ud_hold_ff      <= nxt_ud_hold;
            rh_prev_ff      <= rh_on;
            restore_ff      <= nxt_restore;
            pwr_cnt_ff      <= pwr_done ? pwr_cnt_ff : pwr_cnt_ff + 2'h1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            nv_write_ff <= 1'b0;
            nv_wdata_ff <= '0;
            stat_ff     <= '0;
        end else begin
            nv_write_ff <= nxt_nv_write;
            nv_wdata_ff <= nxt_nv_wdata;
            stat_ff     <= nxt_stat;
        end
    end

    // checks
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (reset);

    sequence s_pwr_window;
        pwr_edge && cfg.hold_select && (act_up || act_dn);
    endsequence
    sequence s_clear_written;
        nv_write_ff && nv_wdata_ff == '0;
    endsequence

    sec_enable_a: assert property (fn_has[dir_pkg::FN_SEC_EN]
        |=> stat_ff.secondary_analog_enable ==
            $past(fn_act[dir_pkg::FN_SEC_EN]))
        else $error("second analog enable does not follow its input");
    drive_enable_a: assert property (run_lat_ff && has_den
        && !act_den |=> !run_lat_ff)
        else $error("run kept after drive enable dropped");
    bypass_gate_a: assert property (has_byp && !act_byp
        |-> !run_go)
        else $error("run honoured with bypass enable open");
    not_enabled_a: assert property (run_s && has_byp && !act_byp
        |=> stat_ff.drive_not_enabled_alarm)
        else $error("drive not enabled alarm missing");
    stop_wins_a: assert property (!run_go
        |-> target == '0 && !ramp_hold)
        else $error("stop did not clear target under hold");
    config_error_a: assert property ((has_up ^ has_dn)
        || (has_ti ^ has_td)
        || ((has_up || has_dn) && has_rh)
        |=> stat_ff.input_config_error)
        else $error("configuration error not flagged");
    ud_limits_a: assert property (ud_mode && run_go && !up_only
        && lo_eff <= cfg.upper_limit
        |-> target >= lo_eff && target <= cfg.upper_limit)
        else $error("raise/lower target outside limits");
    multistep_off_a: assert property (ud_mode
        |=> stat_ff.multistep_disable)
        else $error("multi-step left enabled in raise/lower mode");
    powerup_clear_a: assert property (s_pwr_window
        |=> s_clear_written)
        else $error("stored reference not cleared at power-up");
    speed_agree_a: assert property (stat_ff.speed_agree
        |-> $past(run_s) && !$past(accel) && !$past(decel))
        else $error("speed agree while ramping or stopped");
    trim_floor_a: assert property (td_only && !restore_ff
        && !ud_mode && base_reference < trim_amt && run_go
        |-> target == '0)
        else $error("negative trimmed reference not floored");
endmodule

// ==== dir_field.sv ====
/* dir_field: terminal switches, run contact and non-volatile store
   outside dir_ctrl.
   assumes: requests change at the falling edge of clk_sys. */
`timescale 1ns/1ps
module dir_field (
    input  wire logic                    clk_sys,
    input  wire logic [dir_pkg::NIN-1:0] din_req,
    input  wire logic                    run_req,
    input  wire logic [dir_pkg::NIN-1:0] enable_mask,
    input  wire logic [dir_pkg::FW-1:0]  nv_wdata,
    input  wire logic                    nv_write,
    output logic      [dir_pkg::NIN-1:0] din_pins,
    output logic                         run_pin,
    output logic      [dir_pkg::FW-1:0]  nv_value
);
    logic run_held;
    logic enable_ok;

    // run only closes once every drive enable terminal is on
    assign enable_ok = (din_req & enable_mask) == enable_mask;
    assign run_pin   = run_req & (enable_ok | run_held);
    assign din_pins  = din_req;

    // store keeps its word through reset, as over a power loss
    initial nv_value = 12'h0C8;
    initial run_held = 1'b0;
    always @(posedge clk_sys) begin
        run_held <= run_pin;
        if (nv_write) begin
            nv_value <= nv_wdata;
        end
    end
endmodule

// ==== dir_ctrl_bench.sv ====
/* dir_ctrl_bench: self-checking bench for dir_ctrl.
   assumes: dir_pkg, dir_ctrl and dir_field are compiled first. */
`timescale 1ns/1ps
`define CHK(got, exp) begin \
    n_compared++; \
    if ((got) !== (exp)) begin \
        bad_count++; \
        $display("unexpected %0t got %h exp %h", $time, got, exp); \
    end \
end
module dir_ctrl_bench;
    logic                         clk_sys;
    logic                         reset;
    logic [4:0]                   din_req;
    logic                         run_req;
    logic [4:0]                   en_mask;
    logic [4:0][7:0]              fsel;
    dir_pkg::dir_cfg_t            cfg;
    logic [11:0]                  prim_ain;
    logic [11:0]                  base_ref;
    logic [15:0]                  acc;
    logic [15:0]                  dcc;
    logic [4:0]                   din_pins;
    logic                         run_pin;
    logic [11:0]                  nv_value;
    logic [11:0]                  freq;
    logic [11:0]                  nv_wdata;
    logic                         nv_write;
    dir_pkg::dir_stat_t           stat;
    int                           bad_count = 0;
    int                           n_compared = 0;
    int                           cycles = 0;

    dir_field i_field (.clk_sys(clk_sys), .din_req(din_req),
        .run_req(run_req), .enable_mask(en_mask), .nv_wdata(nv_wdata),
        .nv_write(nv_write), .din_pins(din_pins), .run_pin(run_pin),
        .nv_value(nv_value));
    dir_ctrl i_dut (.clk_sys(clk_sys), .reset(reset),
        .din_pins(din_pins), .run_pin(run_pin),
        .input_function_select(fsel), .cfg(cfg),
        .primary_analog_input(prim_ain), .base_reference(base_ref),
        .accel_cyc(acc), .decel_cyc(dcc), .nv_value(nv_value),
        .output_freq(freq), .nv_wdata_ff(nv_wdata),
        .nv_write_ff(nv_write), .stat_ff(stat));

    task automatic close_out();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge clk_sys);
    endtask

    task automatic defaults();
        run_req = 1'b0;
        din_req = '0;
        en_mask = '0;
        fsel = '0;
        prim_ain = '0;
        base_ref = 12'h020;
        acc = '0;
        dcc = '0;
        cfg = '{dir_pkg::UPPER_LIMIT_RST, dir_pkg::LOWER_LIMIT_RST, 12'h000,
                dir_pkg::TRIM_LEVEL_RST, dir_pkg::HOLD_SEL_RST,
                dir_pkg::STOP_COAST, 1'b1};
    endtask

    task automatic idle();
        defaults();
        cyc(7);
    endtask

    // pins stay put through reset so the settle sample sees them
    task automatic power_up();
        reset = 1'b1;
        cyc(12);
        reset = 1'b0;
        cyc(4);
    endtask

    task automatic t_reset();
        `CHK(freq, 12'h000);
        `CHK(stat, 6'h04);
    endtask

    task automatic t_sec();
        idle();
        fsel[1] = 8'h0C;
        cyc(5);
        `CHK(stat.secondary_analog_enable, 1'b0);
        din_req[1] = 1'b1;
        cyc(5);
        `CHK(stat.secondary_analog_enable, 1'b1);
    endtask

    task automatic t_cfg();
        logic [23:0] tab [0:4];
        logic        err [0:4];
        tab = '{24'h000010, 24'h001110, 24'h0A1110, 24'h00001C, 24'h001D1C};
        err = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
        for (int i = 0; i < 5; i++) begin
            idle();
            fsel[2:0] = tab[i];
            cyc(5);
            `CHK(stat.input_config_error, err[i]);
        end
    endtask

    task automatic t_bypass();
        idle();
        fsel[0] = 8'h70;
        run_req = 1'b1;
        cyc(8);
        `CHK(stat.motor_run, 1'b0);
        `CHK(stat.drive_not_enabled_alarm, 1'b1);
        din_req[0] = 1'b1;
        cyc(40);
        `CHK(stat.drive_not_enabled_alarm, 1'b0);
        `CHK(freq, 12'h020);
        `CHK(stat.speed_agree, 1'b1);
    endtask

    task automatic t_enable();
        idle();
        fsel[0] = 8'h6A;
        en_mask = 5'h01;
        din_req[0] = 1'b1;
        run_req = 1'b1;
        cyc(40);
        `CHK(freq, 12'h020);
        din_req[0] = 1'b0;
        cyc(5);
        `CHK(freq, 12'h000);
        `CHK(stat.motor_run, 1'b0);
    endtask

    task automatic t_hold();
        logic [11:0] f;
        idle();
        fsel[0] = 8'h0A;
        base_ref = 12'h080;
        acc = 16'h0003;
        run_req = 1'b1;
        cyc(40);
        din_req[0] = 1'b1;
        cyc(4);
        f = freq;
        cyc(40);
        `CHK(freq, f);
        din_req[0] = 1'b0;
        cyc(12);
        `CHK(freq > f, 1'b1);
        `CHK(stat.speed_agree, 1'b0);
        din_req[0] = 1'b1;
        cfg.stop_coast = 1'b0;
        run_req = 1'b0;
        cyc(4);
        `CHK(freq != 12'h000, 1'b1);
        cyc(20);
        `CHK(freq, 12'h000);
    endtask

    task automatic t_updown();
        idle();
        fsel[1:0] = 16'h1110;
        cfg.lower_limit = 12'h014;
        cfg.master_lower_limit = 12'h018;
        cfg.upper_limit = 12'h040;
        acc = 16'h0001;
        run_req = 1'b1;
        cyc(60);
        `CHK(freq, 12'h018);
        `CHK(stat.multistep_disable, 1'b1);
        din_req[0] = 1'b1;
        cyc(40);
        `CHK(freq < 12'h040, 1'b1);
        cyc(60);
        `CHK(freq, 12'h040);
        din_req[1] = 1'b1;
        cyc(20);
        `CHK(freq, 12'h040);
        din_req[0] = 1'b0;
        prim_ain = 12'h020;
        cyc(40);
        `CHK(freq, 12'h020);
        prim_ain = 12'h010;
        cyc(20);
        `CHK(freq, 12'h018);
    endtask

    task automatic t_trim();
        logic [33:0] tab [0:7];
        tab = '{{2'b01, 12'h064, 7'h05, 1'b1, 12'h096},
                {2'b10, 12'h064, 7'h05, 1'b1, 12'h032},
                {2'b11, 12'h064, 7'h05, 1'b1, 12'h064},
                {2'b00, 12'h064, 7'h05, 1'b1, 12'h064},
                {2'b10, 12'h014, 7'h05, 1'b1, 12'h000},
                {2'b01, 12'h064, 7'h05, 1'b0, 12'h064},
                {2'b01, 12'h064, 7'h64, 1'b1, 12'h44C},
                {2'b01, 12'h000, 7'h05, 1'b1, 12'h000}};
        for (int i = 0; i < 8; i++) begin
            idle();
            fsel[1:0] = 16'h1D1C;
            {din_req[1:0], base_ref, cfg.trim_level, cfg.ref_src_analog}
                = tab[i][33:12];
            run_req = 1'b1;
            cyc(1110);
            `CHK(freq, tab[i][11:0]);
        end
    endtask

    task automatic t_nv();
        logic [11:0] f;
        idle();
        fsel[1:0] = 16'h1110;
        cfg.upper_limit = 12'h040;
        cfg.hold_select = 1'b1;
        run_req = 1'b1;
        din_req[0] = 1'b1;
        cyc(80);
        din_req[0] = 1'b0;
        cyc(6);
        `CHK(nv_value, 12'h040);
        run_req = 1'b0;
        power_up();
        run_req = 1'b1;
        cyc(80);
        `CHK(freq, 12'h040);
        run_req = 1'b0;
        din_req[0] = 1'b1;
        power_up();
        `CHK(nv_value, 12'h000);
        idle();
        fsel[0] = 8'h0A;
        cfg.hold_select = 1'b1;
        base_ref = 12'h050;
        run_req = 1'b1;
        cyc(30);
        din_req[0] = 1'b1;
        cyc(8);
        `CHK(nv_value, freq);
        f = nv_value;
        run_req = 1'b0;
        din_req[0] = 1'b0;
        power_up();
        run_req = 1'b1;
        cyc(40);
        `CHK(freq, f);
    endtask

    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    // whole run needs about 9800 cycles
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            bad_count++;
            close_out();
        end
    end

    initial begin
        defaults();
        power_up();
        t_reset();
        t_sec();
        t_cfg();
        t_bypass();
        t_enable();
        t_hold();
        t_updown();
        t_trim();
        t_nv();
        close_out();
    end
endmodule
